// ---- rtl/dsr_pkg.sv ----
// constants shared by the serial read path and its location store
package dsr_pkg;
  // command byte layout, most significant bit first
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned ADDR_BITS = 5;
  localparam int unsigned OPC_BITS = 2;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_BITS = 5;
  // bit counter values, counted in sck rising edges seen
  localparam logic [4:0] CNT_ADDR_OPC_LAST = 5'h06;
  localparam logic [4:0] CNT_RESERVED = 5'h07;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h17;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  // operation codes carried in operation_code_field
  localparam logic [1:0] OPC_READ = 2'h3;
  // device resolution: 12, 10 or 8 implemented data bits
  localparam int unsigned DATA_BITS = 12;
  // location map
  localparam int unsigned NUM_LOCATIONS = 32;
  localparam logic [4:0] NV_BASE_ADDR = 5'h10;
  localparam logic [4:0] STATUS_ADDR = 5'h0a;
  localparam int unsigned NVWA_BIT = 7;
  // reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] CMD_RESET = 8'h00;
endpackage : dsr_pkg

// ---- rtl/dsr_mem.sv ----
// location store with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module dsr_mem
  import dsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [dsr_pkg::ADDR_BITS-1:0] wr_addr_i,
  input wire logic [dsr_pkg::WORD_BITS-1:0] wr_data_i,
  input wire logic [dsr_pkg::ADDR_BITS-1:0] rd_addr_i,
  output logic [dsr_pkg::WORD_BITS-1:0] rd_data_o
);
  import dsr_pkg::*;

  logic [WORD_BITS-1:0] mem_q [NUM_LOCATIONS];

  // write from the device side, outside the serial path
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read, one clock of latency
  always_ff @(posedge clk_i)
  begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule // dsr_mem
`default_nettype wire

// ---- rtl/dsr_read_path.sv ----
// serial read command path of the dac spi slave port
`timescale 1ns/1ps
`default_nettype none
module dsr_read_path
  import dsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // device side
  input wire logic nv_write_active_i,
  input wire logic wr_en_i,
  input wire logic [dsr_pkg::ADDR_BITS-1:0] wr_addr_i,
  input wire logic [dsr_pkg::WORD_BITS-1:0] wr_data_i,
  output logic command_error_flag_o,
  output logic read_done_o,
  output logic [dsr_pkg::ADDR_BITS-1:0] read_addr_o
);
  import dsr_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_ERR
  } dsr_state_t;

  logic cs_n_m_q;
  logic cs_n_s_q;
  logic sck_m_q;
  logic sck_s_q;
  logic sck_p_q;
  logic sdi_m_q;
  logic sdi_s_q;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  dsr_state_t state_q;
  dsr_state_t state_d;
  logic [CNT_BITS-1:0] bit_cnt_q;
  logic [CMD_BITS-1:0] cmd_q;
  logic [WORD_BITS-1:0] data_q;
  logic flag_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic [ADDR_BITS-1:0] cur_addr;
  logic [OPC_BITS-1:0] cur_opc;
  logic cmd_valid;
  logic [WORD_BITS-1:0] mem_word;
  logic [WORD_BITS-1:0] read_word;
  logic [WORD_BITS-1:0] data_mask;
  logic sdo_q;
  logic sdo_oe_q;
  logic read_done_q;

  // two flip-flop synchronisers for all pin inputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end
    else
    begin
      cs_n_m_q <= cs_n_i;
      cs_n_s_q <= cs_n_m_q;
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      sdi_m_q <= sdi_i;
      sdi_s_q <= sdi_m_q;
    end
  end

  // sck edges only count while selected
  assign selected = !cs_n_s_q;
  assign sck_rise = selected && sck_s_q && !sck_p_q;
  assign sck_fall = selected && !sck_s_q && sck_p_q;

  // address and opcode of the command completing on this rise
  assign cur_addr = cmd_q[5:1];
  assign cur_opc = {cmd_q[0], sdi_s_q};

  // validity of the address and opcode pair
  always_comb
  begin
    cmd_valid = (cur_opc == OPC_READ);
    if (nv_write_active_i && (cur_addr >= NV_BASE_ADDR))
    begin
      cmd_valid = 1'b0;
    end
  end

  // right justified word, status location carries the write active bit
  assign data_mask = WORD_BITS'((1 << DATA_BITS) - 1);
  always_comb
  begin
    read_word = mem_word & data_mask;
    if (addr_q == STATUS_ADDR)
    begin
      read_word = WORD_RESET;
      read_word[NVWA_BIT] = nv_write_active_i;
    end
  end

  // command state transitions
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (selected)
        begin
          state_d = ST_CMD;
        end
      end
      ST_CMD:
      begin
        if (sck_rise && (bit_cnt_q == CNT_ADDR_OPC_LAST))
        begin
          state_d = cmd_valid ? ST_DATA : ST_ERR;
        end
      end
      ST_DATA:
      begin
        if (sck_rise && (bit_cnt_q == CNT_FRAME_LAST))
        begin
          state_d = ST_CMD;
        end
      end
      ST_ERR:
      begin
        state_d = ST_ERR;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (!selected)
    begin
      state_d = ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // rising edge count within the 24 clock frame
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !selected)
    begin
      bit_cnt_q <= CNT_ZERO;
    end
    else if (sck_rise)
    begin
      if (bit_cnt_q == CNT_FRAME_LAST)
      begin
        bit_cnt_q <= CNT_ZERO;
      end
      else
      begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // command shift register, msb first
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !selected)
    begin
      cmd_q <= CMD_RESET;
    end
    else if (sck_rise && (bit_cnt_q <= CNT_RESERVED))
    begin
      cmd_q <= {cmd_q[CMD_BITS-2:0], sdi_s_q};
    end
  end

  // flag and address captured on the seventh rise
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !selected)
    begin
      flag_q <= 1'b1;
      addr_q <= '0;
    end
    else if (sck_rise && (bit_cnt_q == CNT_ADDR_OPC_LAST)
             && (state_q == ST_CMD))
    begin
      flag_q <= cmd_valid;
      addr_q <= cur_addr;
    end
  end

  // output word loaded on the reserved bit rise, shifted on falls
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !selected)
    begin
      data_q <= WORD_RESET;
    end
    else if (sck_rise && (bit_cnt_q == CNT_RESERVED)
             && (state_q == ST_DATA))
    begin
      data_q <= read_word;
    end
    else if (sck_fall && (bit_cnt_q > CNT_RESERVED))
    begin
      data_q <= {data_q[WORD_BITS-2:0], 1'b0};
    end
  end

  // sdo pin value, changed on sck falls, forced low every clock in the error state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !selected)
    begin
      sdo_q <= 1'b1;
    end
    else if (state_q == ST_ERR)
    begin
      sdo_q <= 1'b0;
    end
    else if (sck_fall)
    begin
      if (bit_cnt_q == CNT_RESERVED)
      begin
        sdo_q <= flag_q;
      end
      else if (bit_cnt_q > CNT_RESERVED)
      begin
        sdo_q <= data_q[WORD_BITS-1];
      end
      else
      begin
        sdo_q <= 1'b1;
      end
    end
  end

  // sdo drives whenever chip select is active
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sdo_oe_q <= 1'b0;
    end
    else
    begin
      sdo_oe_q <= selected;
    end
  end

  // pulse when a full 24 clock read has been delivered
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      read_done_q <= 1'b0;
      read_addr_o <= '0;
    end
    else
    begin
      read_done_q <= sck_rise && (bit_cnt_q == CNT_FRAME_LAST)
                     && (state_q == ST_DATA);
      if (sck_rise && (bit_cnt_q == CNT_FRAME_LAST) && (state_q == ST_DATA))
      begin
        read_addr_o <= addr_q;
      end
    end
  end

  // command error state seen by the rest of the device
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      command_error_flag_o <= 1'b1;
    end
    else
    begin
      command_error_flag_o <= (state_d != ST_ERR);
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe_o = sdo_oe_q;
  assign read_done_o = read_done_q;

  // location store, read address taken from the captured command
  dsr_mem u_mem (
    .clk_i (clk_i),
    .wr_en_i (wr_en_i),
    .wr_addr_i (wr_addr_i),
    .wr_data_i (wr_data_i),
    .rd_addr_i (addr_q),
    .rd_data_o (mem_word)
  );
endmodule // dsr_read_path
`default_nettype wire

// ---- verification/dsr_read_path_props.sv ----
// port checker for the serial read path
`timescale 1ns/1ps
`default_nettype none
module dsr_read_path_props
  import dsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic command_error_flag_o,
  input wire logic read_done_o,
  input wire logic [dsr_pkg::ADDR_BITS-1:0] read_addr_o
);
  import dsr_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // pin level while deselected and selected
  property p_idle; cs_n_i[*6] |-> sdo_o && !sdo_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("sdo not idle");
  property p_oe_on; (!cs_n_i)[*6] |-> sdo_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven");
  property p_oe_off; $rose(cs_n_i) |-> ##[1:5] !sdo_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo kept");
  // error state forces low data and clears on deselect
  property p_err; (!command_error_flag_o && !cs_n_i)[*4] |-> !sdo_o;
  endproperty
  a_err: assert property (p_err) else $error("sdo high in error");
  property p_clr; cs_n_i[*6] |-> command_error_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("error kept");
  // sdo only moves after a falling sck
  property p_hold;
    (sck_i && !cs_n_i && command_error_flag_o)[*7] |-> $stable(sdo_o);
  endproperty
  a_hold: assert property (p_hold) else $error("sdo moved");
  // completion pulse and address report
  property p_done; read_done_o |-> command_error_flag_o; endproperty
  a_done: assert property (p_done) else $error("done in error");
  property p_one; read_done_o |=> !read_done_o; endproperty
  a_one: assert property (p_one) else $error("long done");
  property p_addr; !read_done_o |-> $stable(read_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
endmodule // dsr_read_path_props
`default_nettype wire

// ---- verification/dsr_host.sv ----
// host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module dsr_host (
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic mode3 = 1'b0;
  // idle pins at time zero
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // shift n bits msb first, sdi set after fall, sdo taken at rise
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 24'h000000;
    for (int i = 0; i < n; i++)
    begin
      sck_o = 1'b0;
      sdi_o = tx[23-i];
      #62.5;
      sck_o = 1'b1;
      rx = {rx[22:0], sdo_i};
      #62.5;
    end
    sck_o = mode3;
  endtask
  // select with idle sck level of the mode
  task automatic sel(input logic m);
    mode3 = m;
    sck_o = m;
    #100;
    cs_n_o = 1'b0;
    #100;
  endtask
  // release; stale sdi inverted so it is never mistaken for data
  task automatic desel();
    #100;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule // dsr_host
`default_nettype wire

// ---- verification/test_dsr_read_path.sv ----
// self-checking bench for the serial read path
`timescale 1ns/1ps
`default_nettype none
module test_dsr_read_path;
  import dsr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic nv_i = 1'b0;
  logic we = 1'b0;
  logic [ADDR_BITS-1:0] wa = 5'h00;
  logic [WORD_BITS-1:0] wd = 16'h0000;
  wire logic cs_n, sck, sdi, sdo, flag, done, sdo_oe, sdo_line;
  wire logic [ADDR_BITS-1:0] ra;
  logic [23:0] rx;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] done_cnt = 8'h00;
  always #4 clk_i = ~clk_i;
  // released sdo shows the inverse of its last level to the host
  assign sdo_line = sdo_oe ? sdo : !sdo;
  dsr_read_path u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .nv_write_active_i(nv_i), .wr_en_i(we), .wr_addr_i(wa),
    .wr_data_i(wd), .command_error_flag_o(flag), .read_done_o(done),
    .read_addr_o(ra));
  dsr_host u_host (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
    .sdo_i(sdo_line));
  // verdict and end of run
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t frame %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chka(input logic [ADDR_BITS-1:0] got,
                      input logic [ADDR_BITS-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t addr %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t level %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chkn(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_i);
    we = 1'b1;
    wa = a;
    wd = d;
    @(negedge clk_i);
    we = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] op,
                    input logic [23:0] exp);
    u_host.xfer({a, op, 1'b0, 16'h0000}, 24, rx);
    chk(rx, exp);
  endtask
  // valid frame: seven ones, flag high, word right justified
  function automatic logic [23:0] ok(input logic [15:0] w);
    return {8'hff, w & ~(16'hffff << DATA_BITS)};
  endfunction
  // hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  // completed reads seen on the done pulse
  always @(negedge clk_i)
  begin
    if (done === 1'b1)
      done_cnt <= done_cnt + 8'h01;
  end
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    wr(5'h03, 16'hfabc);
    wr(5'h11, 16'h1234);
    wr(5'h1f, 16'hffff);
    u_host.sel(1'b0);
    chkf(sdo_oe, 1'b1);
    rd(5'h03, OPC_READ, ok(16'hfabc));
    rd(5'h11, OPC_READ, ok(16'h1234));
    rd(5'h1f, OPC_READ, ok(16'hffff));
    #200;
    chka(ra, 5'h1f);
    u_host.desel();
    @(negedge clk_i);
    nv_i = 1'b1;
    u_host.sel(1'b0);
    rd(STATUS_ADDR, OPC_READ, ok(16'h0080));
    rd(5'h11, OPC_READ, 24'hfe0000);
    rd(5'h03, OPC_READ, 24'h000000);
    chkf(flag, 1'b0);
    u_host.desel();
    @(negedge clk_i);
    nv_i = 1'b0;
    chkf(flag, 1'b1);
    chkf(sdo_oe, 1'b0);
    for (int op = 0; op < 3; op++)
    begin
      u_host.sel(1'b0);
      rd(5'h03, 2'(op), 24'hfe0000);
      u_host.desel();
    end
    // partial frame dropped, then mode 3 reads
    u_host.sel(1'b1);
    u_host.xfer(24'hffffff, 10, rx);
    chk(rx, 24'h0003fc);
    u_host.desel();
    u_host.sel(1'b1);
    rd(5'h1f, OPC_READ, ok(16'hffff));
    rd(STATUS_ADDR, OPC_READ, ok(16'h0000));
    u_host.desel();
    chkn(done_cnt, 8'h06);
    finish_test();
  end
endmodule // test_dsr_read_path
bind dsr_read_path dsr_read_path_props u_props (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .command_error_flag_o(command_error_flag_o),
  .read_done_o(read_done_o), .read_addr_o(read_addr_o));
`default_nettype wire
